// *** hdl/ptp_rtc_control.sv ***
// Operation
// - Read command snapshots running time into holds
// - Load command copies holds into running time
// - Continuous adjustment applies rate each timebase tick
// - Time advances only while enable is set
// - Reset command zeroes running time, self-clears
// - Phase shows 8 ns step in period
// - Phase codes five to seven never appear
// - Nanoseconds split into high, low halves
// - Seconds split into high, low halves
// - Step direction zero subtracts held nanoseconds
// - Step command adds or subtracts held nanoseconds
// - Rate direction one adds, zero subtracts
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ptp_rtc_control (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [15:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [15:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i
);
    typedef struct packed {
        logic aw_full;
        logic [13:0] aw_idx;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [6:0] ctrl;
        logic [2:0] hold_phase;
        logic [15:0] ns_hi;
        logic [15:0] ns_lo;
        logic [15:0] sec_hi;
        logic [15:0] sec_lo;
        logic rate_dir;
        logic [rtc_pkg::RATE_W-1:0] rate;
    } reg_state_s;

    reg_state_s st;
    reg_state_s next_st;
    logic wr_go;
    logic wr_ctrl;
    logic [31:0] merged;
    logic [31:0] hold_ns;
    logic [32:0] step_sum;

    rtc_cmd_if t();

    function automatic logic is_mapped(input logic [13:0] idx);
        return idx == rtc_pkg::IDX_CTRL || idx == rtc_pkg::IDX_PHASE
            || idx == rtc_pkg::IDX_NS_HI || idx == rtc_pkg::IDX_NS_LO
            || idx == rtc_pkg::IDX_SEC_HI || idx == rtc_pkg::IDX_SEC_LO
            || idx == rtc_pkg::IDX_RATE;
    endfunction

    // Unused upper bits of the 16-bit registers read as zero
    function automatic logic [31:0] read_value(input reg_state_s s, input logic [13:0] idx);
        logic [31:0] v;
        v = 32'h0;
        unique case (idx)
            rtc_pkg::IDX_CTRL: v = 32'(s.ctrl);
            rtc_pkg::IDX_PHASE: v = 32'(s.hold_phase);
            rtc_pkg::IDX_NS_HI: v = 32'(s.ns_hi);
            rtc_pkg::IDX_NS_LO: v = 32'(s.ns_lo);
            rtc_pkg::IDX_SEC_HI: v = 32'(s.sec_hi);
            rtc_pkg::IDX_SEC_LO: v = 32'(s.sec_lo);
            rtc_pkg::IDX_RATE: v = {s.rate_dir, 1'b0, s.rate};
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] merge_lanes(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return v;
    endfunction

    assign wr_go = st.aw_full && st.w_full && !st.b_valid;
    assign wr_ctrl = wr_go && st.aw_idx == rtc_pkg::IDX_CTRL;
    assign merged = merge_lanes(read_value(st, st.aw_idx), st.w_data, st.w_strb);
    assign hold_ns = {st.ns_hi, st.ns_lo};
    assign step_sum = {1'b0, t.ns} + {1'b0, hold_ns};

    always_comb begin
        next_st = st;
        if (awvalid_i && !st.aw_full) begin
            next_st.aw_full = 1'b1;
            next_st.aw_idx = awaddr_i[15:2];
        end
        if (wvalid_i && !st.w_full) begin
            next_st.w_full = 1'b1;
            next_st.w_data = wdata_i;
            next_st.w_strb = wstrb_i;
        end
        if (st.b_valid && bready_i) begin
            next_st.b_valid = 1'b0;
        end
        if (st.r_valid && rready_i) begin
            next_st.r_valid = 1'b0;
        end
        if (arvalid_i && !st.r_valid) begin
            next_st.r_valid = 1'b1;
            next_st.r_data = read_value(st, araddr_i[15:2]);
            next_st.r_resp = is_mapped(araddr_i[15:2]) ? rtc_pkg::RESP_OKAY
                : rtc_pkg::RESP_SLVERR;
        end
        // Commands act on the edge after they are set, then drop
        next_st.ctrl = st.ctrl & ~rtc_pkg::SC_MASK;
        if (st.ctrl[rtc_pkg::CTRL_READ]) begin
            next_st.hold_phase = t.phase;
            next_st.ns_hi = t.ns[31:16];
            next_st.ns_lo = t.ns[15:0];
            next_st.sec_hi = t.sec[31:16];
            next_st.sec_lo = t.sec[15:0];
        end
        if (wr_go) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.b_valid = 1'b1;
            next_st.b_resp = is_mapped(st.aw_idx) ? rtc_pkg::RESP_OKAY
                : rtc_pkg::RESP_SLVERR;
            unique case (st.aw_idx)
                rtc_pkg::IDX_CTRL: begin
                    next_st.ctrl[rtc_pkg::CTRL_EN] = merged[rtc_pkg::CTRL_EN];
                    next_st.ctrl[rtc_pkg::CTRL_CONT] = merged[rtc_pkg::CTRL_CONT];
                    next_st.ctrl[rtc_pkg::CTRL_STEP_DIR] = merged[rtc_pkg::CTRL_STEP_DIR];
                    // Set wins over the self-clear; writing zero cannot cancel
                    if (st.w_strb[0]) begin
                        next_st.ctrl = next_st.ctrl
                            | (st.w_data[6:0] & rtc_pkg::SC_MASK);
                    end
                end
                rtc_pkg::IDX_PHASE: begin
                    if (merged[2:0] <= rtc_pkg::PHASE_MAX) begin
                        next_st.hold_phase = merged[2:0];
                    end
                end
                rtc_pkg::IDX_NS_HI: next_st.ns_hi = merged[15:0];
                rtc_pkg::IDX_NS_LO: next_st.ns_lo = merged[15:0];
                rtc_pkg::IDX_SEC_HI: next_st.sec_hi = merged[15:0];
                rtc_pkg::IDX_SEC_LO: next_st.sec_lo = merged[15:0];
                rtc_pkg::IDX_RATE: begin
                    next_st.rate_dir = merged[rtc_pkg::RATE_DIR_POS];
                    next_st.rate = merged[rtc_pkg::RATE_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.ctrl <= rtc_pkg::CTRL_RESET;
            st.hold_phase <= rtc_pkg::HOLD_RESET[2:0];
            st.ns_hi <= rtc_pkg::HOLD_RESET;
            st.ns_lo <= rtc_pkg::HOLD_RESET;
            st.sec_hi <= rtc_pkg::HOLD_RESET;
            st.sec_lo <= rtc_pkg::HOLD_RESET;
            st.rate_dir <= rtc_pkg::RATE_RESET[rtc_pkg::RATE_DIR_POS];
            st.rate <= rtc_pkg::RATE_RESET[rtc_pkg::RATE_W-1:0];
        end else begin
            st <= next_st;
        end
    end

    assign t.enable = st.ctrl[rtc_pkg::CTRL_EN];
    assign t.cont_adj = st.ctrl[rtc_pkg::CTRL_CONT];
    assign t.rate_dir = st.rate_dir;
    assign t.rate = st.rate;
    assign t.clear = st.ctrl[rtc_pkg::CTRL_RST];
    assign t.load = st.ctrl[rtc_pkg::CTRL_LOAD];
    assign t.step = st.ctrl[rtc_pkg::CTRL_STEP];
    assign t.step_add = st.ctrl[rtc_pkg::CTRL_STEP_DIR];
    assign t.load_phase = st.hold_phase;
    assign t.load_ns = hold_ns;
    assign t.load_sec = {st.sec_hi, st.sec_lo};

    rtc_time_keeper keeper_u (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .k(t)
    );

    rtc_rate_accum rate_u (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .r(t)
    );

    assign awready_o = !st.aw_full;
    assign wready_o = !st.w_full;
    assign bvalid_o = st.b_valid;
    assign bresp_o = st.b_resp;
    assign arready_o = !st.r_valid;
    assign rvalid_o = st.r_valid;
    assign rdata_o = st.r_data;
    assign rresp_o = st.r_resp;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence snap_req;
        st.ctrl[rtc_pkg::CTRL_READ] && !wr_go;
    endsequence

    sequence load_req;
        st.ctrl[rtc_pkg::CTRL_LOAD] && !st.ctrl[rtc_pkg::CTRL_RST];
    endsequence

    sequence quiet_cmds;
        !st.ctrl[rtc_pkg::CTRL_RST] && !st.ctrl[rtc_pkg::CTRL_LOAD];
    endsequence

    sequence step_alone;
        st.ctrl[rtc_pkg::CTRL_STEP] && !st.ctrl[rtc_pkg::CTRL_EN] ##0 quiet_cmds;
    endsequence

    a_snap_time: assert property (
        snap_req |=> hold_ns == $past(t.ns) && {st.sec_hi, st.sec_lo} == $past(t.sec)
            && st.hold_phase == $past(t.phase))
        else $error("snapshot does not match running time");

    a_load_time: assert property (
        load_req |=> t.ns == $past(hold_ns) && t.sec == $past(t.load_sec)
            && t.phase == $past(st.hold_phase))
        else $error("load did not copy holds into running time");

    a_frozen_time: assert property (
        !st.ctrl[rtc_pkg::CTRL_EN] && !st.ctrl[rtc_pkg::CTRL_STEP] ##0 quiet_cmds
            |=> $stable(t.ns) && $stable(t.phase) && $stable(t.sec))
        else $error("time moved while disabled");

    a_clear_zero: assert property (
        st.ctrl[rtc_pkg::CTRL_RST] |=> t.ns == 32'h0 && t.sec == 32'h0 && t.phase == 3'h0
            ##1 !st.ctrl[rtc_pkg::CTRL_RST] || $past(wr_ctrl))
        else $error("reset command did not zero the time");

    a_phase_valid: assert property (
        st.hold_phase <= rtc_pkg::PHASE_MAX && t.phase <= rtc_pkg::PHASE_MAX)
        else $error("invalid phase code visible");

    a_step_sub: assert property (
        step_alone ##0 !st.ctrl[rtc_pkg::CTRL_STEP_DIR] && t.ns >= hold_ns
            |=> t.ns == $past(t.ns) - $past(hold_ns) && $stable(t.sec))
        else $error("step subtract gave wrong time");

    a_step_add: assert property (
        step_alone ##0 st.ctrl[rtc_pkg::CTRL_STEP_DIR] && step_sum < 33'(rtc_pkg::NS_PER_SEC)
            |=> t.ns == $past(step_sum[31:0]) && $stable(t.sec))
        else $error("step add gave wrong time");

    a_sc_clear: assert property (
        (st.ctrl & rtc_pkg::SC_MASK) != 7'h0 && !wr_ctrl
            |=> (st.ctrl & rtc_pkg::SC_MASK) == 7'h0)
        else $error("command bit did not self-clear");

    a_sc_visible: assert property (
        wr_ctrl && st.w_strb[0] && st.w_data[rtc_pkg::CTRL_READ]
            |=> st.ctrl[rtc_pkg::CTRL_READ] ##1 !st.ctrl[rtc_pkg::CTRL_READ] || $past(wr_ctrl))
        else $error("read command not shown pending for one cycle");

    a_write_resp: assert property (
        wr_go |=> bvalid_o && awready_o && wready_o)
        else $error("write response missing");

    sequence read_taken;
        arvalid_i && arready_o;
    endsequence

    a_read_answer: assert property (
        read_taken |=> rvalid_o)
        else $error("read data not returned");

    a_read_unmapped: assert property (
        read_taken ##0 !is_mapped(araddr_i[15:2])
            |=> rresp_o == rtc_pkg::RESP_SLVERR && rdata_o == 32'h0)
        else $error("unmapped read not refused");

    a_b_hold: assert property (
        bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped before accepted");

    a_b_done: assert property (
        bvalid_o && bready_i |=> !bvalid_o)
        else $error("write response repeated");

    a_r_hold: assert property (
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
        else $error("read data dropped before accepted");

    a_r_done: assert property (
        rvalid_o && rready_i |=> !rvalid_o)
        else $error("read data repeated");

    a_aw_wait: assert property (
        !awready_o && !wr_go |=> !awready_o)
        else $error("write address slot freed early");

    a_w_wait: assert property (
        !wready_o && !wr_go |=> !wready_o)
        else $error("write data slot freed early");

    a_phase_drop: assert property (
        wr_go && st.aw_idx == rtc_pkg::IDX_PHASE && merged[2:0] > rtc_pkg::PHASE_MAX
            && !st.ctrl[rtc_pkg::CTRL_READ] |=> $stable(st.hold_phase))
        else $error("invalid phase code was stored");

    a_sc_strobe: assert property (
        wr_ctrl && !st.w_strb[0] && (st.ctrl & rtc_pkg::SC_MASK) == 7'h0
            |=> (st.ctrl & rtc_pkg::SC_MASK) == 7'h0)
        else $error("command fired without its byte lane");
endmodule
`default_nettype wire

// *** hdl/rtc_pkg.sv ***
package rtc_pkg;
    // Timing
    localparam int CLOCK_HZ = 40_000_000;
    localparam int CLOCK_NS = 1_000_000_000 / CLOCK_HZ;
    localparam int TB_PERIOD_NS = 40;
    localparam int PHASE_NS = 8;
    localparam logic [31:0] NS_PER_SEC = 32'h3b9a_ca00;
    localparam logic [2:0] PHASE_MAX = 3'h4;
    localparam int RATE_W = 30;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_CTRL = 14'h0500;
    localparam logic [13:0] IDX_PHASE = 14'h0502;
    localparam logic [13:0] IDX_NS_HI = 14'h0504;
    localparam logic [13:0] IDX_NS_LO = 14'h0506;
    localparam logic [13:0] IDX_SEC_HI = 14'h0508;
    localparam logic [13:0] IDX_SEC_LO = 14'h050a;
    localparam logic [13:0] IDX_RATE = 14'h050c;

    // Control field positions
    localparam int CTRL_STEP = 6;
    localparam int CTRL_STEP_DIR = 5;
    localparam int CTRL_READ = 4;
    localparam int CTRL_LOAD = 3;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_EN = 1;
    localparam int CTRL_RST = 0;
    localparam logic [6:0] SC_MASK = 7'h59;
    localparam int RATE_DIR_POS = 31;

    // Reset values
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [15:0] HOLD_RESET = 16'h0000;
    localparam logic [31:0] RATE_RESET = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/rtc_cmd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rtc_cmd_if;
    logic enable;
    logic cont_adj;
    logic rate_dir;
    logic [rtc_pkg::RATE_W-1:0] rate;
    logic clear;
    logic load;
    logic step;
    logic step_add;
    logic [2:0] load_phase;
    logic [31:0] load_ns;
    logic [31:0] load_sec;
    logic tick;
    logic adj_up;
    logic adj_dn;
    logic [2:0] phase;
    logic [31:0] ns;
    logic [31:0] sec;

    modport ctrl (output enable, cont_adj, rate_dir, rate, clear, load, step,
        output step_add, load_phase, load_ns, load_sec, input phase, ns, sec);
    modport keeper (input enable, clear, load, step, step_add, load_phase,
        input load_ns, load_sec, adj_up, adj_dn, output tick, phase, ns, sec);
    modport rater (input enable, cont_adj, rate_dir, rate, clear, tick,
        output adj_up, adj_dn);
endinterface
`default_nettype wire

// *** hdl/rtc_rate_accum.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtc_rate_accum (
    input wire logic clock_i,
    input wire logic rst_b_i,
    rtc_cmd_if.rater r
);
    typedef struct packed {
        logic [rtc_pkg::RATE_W-1:0] frac;
        logic up;
        logic dn;
    } rate_state_s;

    rate_state_s st;
    rate_state_s next_st;
    logic active;
    logic carry;
    logic [rtc_pkg::RATE_W:0] sum;
    logic [rtc_pkg::RATE_W:0] diff;

    assign active = r.enable && r.cont_adj && r.tick;
    assign sum = {1'b0, st.frac} + {1'b0, r.rate};
    assign diff = {1'b0, st.frac} - {1'b0, r.rate};
    assign carry = sum[rtc_pkg::RATE_W];

    // Fraction overflow becomes a one-nanosecond nudge for the keeper
    always_comb begin
        next_st = st;
        next_st.up = 1'b0;
        next_st.dn = 1'b0;
        if (r.clear) begin
            next_st = '0;
        end else if (active && r.rate_dir) begin
            next_st.frac = sum[rtc_pkg::RATE_W-1:0];
            next_st.up = carry;
        end else if (active) begin
            next_st.frac = diff[rtc_pkg::RATE_W-1:0];
            next_st.dn = diff[rtc_pkg::RATE_W];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign r.adj_up = st.up;
    assign r.adj_dn = st.dn;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_rate_carry: assert property (
        active && r.rate_dir && !r.clear |=> r.adj_up == $past(carry) && !r.adj_dn)
        else $error("rate add carry not passed on");
    a_rate_idle: assert property (
        !active |=> !r.adj_up && !r.adj_dn)
        else $error("rate nudge without active adjustment");
endmodule
`default_nettype wire

// *** hdl/rtc_time_keeper.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtc_time_keeper (
    input wire logic clock_i,
    input wire logic rst_b_i,
    rtc_cmd_if.keeper k
);
    typedef struct packed {
        logic [5:0] resid;
        logic [2:0] phase;
        logic [31:0] ns;
        logic [31:0] sec;
    } time_state_s;

    localparam logic signed [34:0] NS_SEC_S = 35'(rtc_pkg::NS_PER_SEC);

    time_state_s st;
    time_state_s next_st;
    logic wrap;
    logic [6:0] resid_sum;
    logic signed [34:0] ns_sum;
    logic [31:0] sec_sum;

    // Residue counts nanoseconds inside the 40 ns period at 25 ns per clock
    assign resid_sum = 7'(st.resid) + 7'(rtc_pkg::CLOCK_NS);
    assign wrap = resid_sum >= 7'(rtc_pkg::TB_PERIOD_NS);
    assign k.tick = k.enable && wrap;

    always_comb begin
        next_st = st;
        ns_sum = 35'(st.ns);
        sec_sum = st.sec;
        if (k.enable) begin
            if (wrap) begin
                next_st.resid = 6'(resid_sum - 7'(rtc_pkg::TB_PERIOD_NS));
                ns_sum = ns_sum + 35'(rtc_pkg::TB_PERIOD_NS);
            end else begin
                next_st.resid = resid_sum[5:0];
            end
            if (k.adj_up) begin
                ns_sum = ns_sum + 35'sd1;
            end
            if (k.adj_dn) begin
                ns_sum = ns_sum - 35'sd1;
            end
        end
        if (k.step && k.step_add) begin
            ns_sum = ns_sum + 35'(k.load_ns);
        end else if (k.step) begin
            ns_sum = ns_sum - 35'(k.load_ns);
        end
        if (ns_sum >= NS_SEC_S) begin
            ns_sum = ns_sum - NS_SEC_S;
            sec_sum = sec_sum + 32'h1;
        end else if (ns_sum < 35'sd0) begin
            ns_sum = ns_sum + NS_SEC_S;
            sec_sum = sec_sum - 32'h1;
        end
        next_st.ns = ns_sum[31:0];
        next_st.sec = sec_sum;
        if (k.load) begin
            next_st.resid = 6'(k.load_phase) * 6'(rtc_pkg::PHASE_NS);
            next_st.ns = k.load_ns;
            next_st.sec = k.load_sec;
        end
        if (k.clear) begin
            next_st = '0;
        end
        next_st.phase = 3'(next_st.resid / 6'(rtc_pkg::PHASE_NS));
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign k.phase = st.phase;
    assign k.ns = st.ns;
    assign k.sec = st.sec;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_phase_range: assert property (
        st.resid < 6'(rtc_pkg::TB_PERIOD_NS) && k.phase <= rtc_pkg::PHASE_MAX)
        else $error("time residue or phase code out of range");
endmodule
`default_nettype wire

// *** test/ptp_rtc_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptp_rtc_control_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] d, ns, sec, ns0, sec0, e;
    logic [2:0] ph, ph0;
    int t0;

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ptp_rtc_control dut (.clock_i(clk), .rst_b_i(rst_b), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready));

    function automatic logic [31:0] cb(input int b);
        return 32'h0000_0001 << b;
    endfunction

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Range compare; an unknown makes the test come out non-one and fail
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        chk({31'h0, bvalid}, 32'h1, 32'h1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, {30'h0, er});
    endtask

    task automatic rd(input logic [13:0] idx, input logic [1:0] er, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        chk({31'h0, rvalid}, 32'h1, 32'h1);
        v = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er}, {30'h0, er});
    endtask

    task automatic rdc(input logic [13:0] idx, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] v;
        rd(idx, rtc_pkg::RESP_OKAY, v);
        chk(v, lo, hi);
    endtask

    // Commands finish within a few cycles, so a short poll bound is enough
    task automatic cmd(input logic [31:0] v);
        logic [31:0] r;
        int n;
        n = 0;
        wr(rtc_pkg::IDX_CTRL, v, rtc_pkg::RESP_OKAY);
        do begin
            rd(rtc_pkg::IDX_CTRL, rtc_pkg::RESP_OKAY, r);
            n++;
        end while ((r[6:0] & rtc_pkg::SC_MASK) !== 7'h00 && n < 8);
        chk({25'h0, r[6:0] & rtc_pkg::SC_MASK}, 32'h0, 32'h0);
    endtask

    task automatic set_time(input logic [2:0] p, input logic [31:0] n, input logic [31:0] s);
        wr(rtc_pkg::IDX_PHASE, {29'h0, p}, rtc_pkg::RESP_OKAY);
        wr(rtc_pkg::IDX_NS_HI, {16'h0, n[31:16]}, rtc_pkg::RESP_OKAY);
        wr(rtc_pkg::IDX_NS_LO, {16'h0, n[15:0]}, rtc_pkg::RESP_OKAY);
        wr(rtc_pkg::IDX_SEC_HI, {16'h0, s[31:16]}, rtc_pkg::RESP_OKAY);
        wr(rtc_pkg::IDX_SEC_LO, {16'h0, s[15:0]}, rtc_pkg::RESP_OKAY);
    endtask

    task automatic get_time(output logic [2:0] p, output logic [31:0] n, output logic [31:0] s);
        logic [31:0] a, b;
        rd(rtc_pkg::IDX_PHASE, rtc_pkg::RESP_OKAY, a);
        p = a[2:0];
        chk(a, 32'h0, {29'h0, rtc_pkg::PHASE_MAX});
        rd(rtc_pkg::IDX_NS_HI, rtc_pkg::RESP_OKAY, a);
        rd(rtc_pkg::IDX_NS_LO, rtc_pkg::RESP_OKAY, b);
        n = {a[15:0], b[15:0]};
        chk(a | b, 32'h0, 32'h0000_ffff);
        rd(rtc_pkg::IDX_SEC_HI, rtc_pkg::RESP_OKAY, a);
        rd(rtc_pkg::IDX_SEC_LO, rtc_pkg::RESP_OKAY, b);
        s = {a[15:0], b[15:0]};
        chk(a | b, 32'h0, 32'h0000_ffff);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(44899));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) rdc(rtc_pkg::IDX_CTRL + 14'(2 * i), 32'h0, 32'h0);
        rd(14'h0501, rtc_pkg::RESP_SLVERR, d);
        chk(d, 32'h0, 32'h0);
        wr(14'h0501, 32'hffff_ffff, rtc_pkg::RESP_SLVERR);
        // Lane 0 masked: low byte keeps its value and no command fires
        wstrb <= 4'h2;
        wr(rtc_pkg::IDX_NS_LO, 32'h0000_ab01, rtc_pkg::RESP_OKAY);
        wr(rtc_pkg::IDX_CTRL, 32'h0000_0001, rtc_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rdc(rtc_pkg::IDX_NS_LO, 32'h0000_ab00, 32'h0000_ab00);
        rdc(rtc_pkg::IDX_CTRL, 32'h0, 32'h0);
        $display("test reset_values done");

        for (int i = 0; i < 4; i++) begin
            ph0 = 3'($urandom_range(4));
            // Held nanoseconds above one second would renormalise at once
            ns0 = $urandom_range(32'd999_999_999);
            sec0 = $urandom();
            set_time(ph0, ns0, sec0);
            wr(rtc_pkg::IDX_PHASE, 32'h0000_0005 + 32'(i % 3), rtc_pkg::RESP_OKAY);
            get_time(ph, ns, sec);
            chk({ph, ns, sec} == {ph0, ns0, sec0}, 32'h1, 32'h1);
            cmd(cb(rtc_pkg::CTRL_LOAD));
            set_time(3'h0, 32'h0, 32'h0);
            repeat (50) @(posedge clk);
            cmd(cb(rtc_pkg::CTRL_READ));
            get_time(ph, ns, sec);
            chk({ph, ns, sec} == {ph0, ns0, sec0}, 32'h1, 32'h1);
        end
        $display("test load_read done");

        for (int dir = 0; dir < 3; dir++) begin
            ns0 = (dir == 1) ? 32'd999_999_900 : 32'd500_000_000;
            d = (dir == 1) ? 32'd200 : $urandom_range(400_000_000);
            set_time(3'h0, ns0, 32'd3);
            cmd(cb(rtc_pkg::CTRL_LOAD));
            set_time(3'h0, d, 32'd0);
            cmd(cb(rtc_pkg::CTRL_STEP) | (dir ? cb(rtc_pkg::CTRL_STEP_DIR) : 32'h0));
            cmd(cb(rtc_pkg::CTRL_READ));
            get_time(ph, ns, sec);
            e = (dir == 0) ? ns0 - d : ((dir == 1) ? 32'd100 : ns0 + d);
            chk(ns, e, e);
            chk(sec, (dir == 1) ? 32'd4 : 32'd3, (dir == 1) ? 32'd4 : 32'd3);
        end
        $display("test step done");

        // Rate field near one full ns each tick makes the drift easy to see
        for (int dir = 0; dir < 3; dir++) begin
            wr(rtc_pkg::IDX_RATE, {dir[0], 1'b0, 30'h3fff_ffff}, rtc_pkg::RESP_OKAY);
            set_time(3'h0, 32'h0, 32'd7);
            cmd(cb(rtc_pkg::CTRL_LOAD));
            d = cb(rtc_pkg::CTRL_EN) | (dir < 2 ? cb(rtc_pkg::CTRL_CONT) : 32'h0);
            wr(rtc_pkg::IDX_CTRL, d, rtc_pkg::RESP_OKAY);
            t0 = cyc;
            repeat (800 + $urandom_range(40)) @(posedge clk);
            t0 = cyc - t0;
            cmd(d | cb(rtc_pkg::CTRL_READ));
            wr(rtc_pkg::IDX_CTRL, 32'h0, rtc_pkg::RESP_OKAY);
            get_time(ph, ns, sec);
            e = 32'(t0 * 25);
            if (dir < 2) e = dir ? e + 32'(t0 * 5 / 8) : e - 32'(t0 * 5 / 8);
            chk(ns + 32'(ph * rtc_pkg::PHASE_NS), e - 32'd120, e + 32'd120);
            chk(sec, 32'd7, 32'd7);
        end
        $display("test run_rate done");

        cmd(cb(rtc_pkg::CTRL_RST));
        cmd(cb(rtc_pkg::CTRL_READ));
        get_time(ph, ns, sec);
        chk({29'h0, ph} | ns | sec, 32'h0, 32'h0);
        $display("test clock_reset done");
        summarize();
    end
endmodule
`default_nettype wire
